// ===== src/hgv_verb_decoder.sv
// verb decoder for pin sense, config default, beep, gpio and function reset
// ============================================================================
`timescale 1ns/1ps
module hgv_verb_decoder
(
  input wire logic ref_clk_in, // 10 MHz clock
  input wire logic sys_rst_in, // power-on reset, async, active high
  input wire logic link_rst_n_in, // link reset pin, active low
  input wire logic [3:0] codec_link_address_in, // codec address strap pin
  input wire logic cmd_valid_in, // command word strobe
  input wire logic [31:0] cmd_data_in, // command word
  output logic resp_valid_out, // response strobe
  output logic [31:0] resp_data_out, // response word
  output logic unsol_valid_out, // unsolicited response strobe
  output logic [31:0] unsol_data_out, // unsolicited response word
  input wire logic [9:0] pin_presence_in, // presence detect pins
  output logic [9:0] sense_right_out, // per pin ring channel select
  input wire logic [15:0] digital_converter_control_bits_out_in, // node 06h bits
  input wire logic [15:0] digital_converter_control_bits_in_in, // node 0Ah bits
  input wire logic [1:0] gpio_in, // gpio pad input level
  output logic [1:0] gpio_out, // gpio pad output level
  output logic [1:0] gpio_oe_out, // gpio pad drive enable
  input wire logic external_beep_input_in, // external beep pin
  output logic beep_out // beep tone out
);
  // ==========================================================================
  // functions
  function automatic logic is_pin(input logic [7:0] node_identifier);
    is_pin = (node_identifier >= hgv_pkg::NID_PORT_FIRST && node_identifier <= hgv_pkg::NID_PORT_LAST)
             || node_identifier == hgv_pkg::NID_PIN_1E || node_identifier == hgv_pkg::NID_PIN_1F;
  endfunction

  function automatic logic [3:0] pin_index(input logic [7:0] node_identifier);
    logic [7:0] off;
    off = node_identifier - hgv_pkg::NID_PORT_FIRST;
    if (node_identifier == hgv_pkg::NID_PIN_1E)
      pin_index = 4'h8;
    else if (node_identifier == hgv_pkg::NID_PIN_1F)
      pin_index = 4'h9;
    else
      pin_index = off[3:0];
  endfunction

  // unsol slots: 0..7 ports, 8 node 0Ah, 9 node 01h
  function automatic logic has_unsol(input logic [7:0] node_identifier);
    has_unsol = (node_identifier >= hgv_pkg::NID_PORT_FIRST && node_identifier <= hgv_pkg::NID_PORT_LAST)
                || node_identifier == hgv_pkg::NID_DIG_IN || node_identifier == hgv_pkg::NID_AFG;
  endfunction

  function automatic logic [3:0] unsol_index(input logic [7:0] node_identifier);
    logic [7:0] off;
    off = node_identifier - hgv_pkg::NID_PORT_FIRST;
    if (node_identifier == hgv_pkg::NID_DIG_IN)
      unsol_index = 4'h8;
    else if (node_identifier == hgv_pkg::NID_AFG)
      unsol_index = 4'h9;
    else
      unsol_index = off[3:0];
  endfunction

  // ==========================================================================
  // input synchronisers
  logic [1:0] link_rst_sync;
  logic [3:0] cad_s1;
  logic [3:0] cad_s2;
  logic [9:0] pres_s1;
  logic [9:0] pres_s2;
  logic [1:0] gpio_s1;
  logic [1:0] gpio_s2;
  logic beep_s1;
  logic beep_s2;

  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      link_rst_sync <= 2'h0;
      {cad_s1, pres_s1, gpio_s1, beep_s1} <= 17'h00000;
      {cad_s2, pres_s2, gpio_s2, beep_s2} <= 17'h00000;
    end
    else
    begin
      link_rst_sync <= {link_rst_sync[0], link_rst_n_in};
      {cad_s1, pres_s1, gpio_s1, beep_s1} <= {codec_link_address_in, pin_presence_in, gpio_in,
        external_beep_input_in};
      {cad_s2, pres_s2, gpio_s2, beep_s2} <= {cad_s1, pres_s1, gpio_s1, beep_s1};
    end
  end

  // ==========================================================================
  // command decode
  logic link_in_reset;
  logic cmd_take;
  logic [7:0] node_identifier;
  logic [11:0] verb;
  logic [7:0] payload;
  logic afg;
  logic func_reset;
  logic soft_clr;

  assign link_in_reset = ~link_rst_sync[1];
  assign cmd_take = cmd_valid_in && !link_in_reset
                    && cmd_data_in[hgv_pkg::CAD_MSB:hgv_pkg::CAD_LSB] == cad_s2;
  assign node_identifier = cmd_data_in[hgv_pkg::NID_MSB:hgv_pkg::NID_LSB];
  assign verb = cmd_data_in[hgv_pkg::VERB_MSB:hgv_pkg::VERB_LSB];
  assign payload = cmd_data_in[7:0];
  assign afg = (node_identifier == hgv_pkg::NID_AFG);
  assign func_reset = cmd_take && afg && verb == hgv_pkg::VERB_FUNC_RESET;
  // link reset and function reset clear everything but the config words
  assign soft_clr = link_in_reset || func_reset;

  // ==========================================================================
  // state registers
  logic [7:0] unsol_ctl [10];
  logic [31:0] cfg_word [hgv_pkg::NUM_PINS];
  logic [7:0] beep_div;
  logic [1:0] gpio_data;
  logic [1:0] gpio_en;
  logic [1:0] gpio_dir;
  logic [1:0] gpio_unsol_mask;
  logic [1:0] gpio_level;
  logic [1:0] gpio_level_q;

  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      for (int i = 0; i < 10; i++)
        unsol_ctl[i] <= hgv_pkg::UNSOL_CTL_RST;
    else if (soft_clr)
      for (int i = 0; i < 10; i++)
        unsol_ctl[i] <= hgv_pkg::UNSOL_CTL_RST;
    else if (cmd_take && verb == hgv_pkg::VERB_SET_UNSOL && has_unsol(node_identifier))
      unsol_ctl[unsol_index(node_identifier)] <= payload & hgv_pkg::UNSOL_KEEP_MASK;
  end

  // only power-on reset touches the config words
  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      for (int i = 0; i < hgv_pkg::NUM_PINS; i++)
        cfg_word[i] <= hgv_pkg::CFG_DEFAULT_RST;
    else if (cmd_take && is_pin(node_identifier))
    begin
      unique case (verb)
        hgv_pkg::VERB_SET_CFG0: cfg_word[pin_index(node_identifier)][7:0] <= payload;
        hgv_pkg::VERB_SET_CFG1: cfg_word[pin_index(node_identifier)][15:8] <= payload;
        hgv_pkg::VERB_SET_CFG2: cfg_word[pin_index(node_identifier)][23:16] <= payload;
        hgv_pkg::VERB_SET_CFG3: cfg_word[pin_index(node_identifier)][31:24] <= payload;
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      sense_right_out <= 10'h000;
    else if (soft_clr)
      sense_right_out <= 10'h000;
    else if (cmd_take && verb == hgv_pkg::VERB_EXEC_SENSE && is_pin(node_identifier))
      sense_right_out[pin_index(node_identifier)] <= payload[0];
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      beep_div <= hgv_pkg::BEEP_DIV_RST;
    else if (soft_clr)
      beep_div <= hgv_pkg::BEEP_DIV_RST;
    else if (cmd_take && afg && verb == hgv_pkg::VERB_SET_BEEP)
      beep_div <= payload;
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      {gpio_data, gpio_en, gpio_dir, gpio_unsol_mask} <= {4{hgv_pkg::GPIO_RST}};
    else if (soft_clr)
      {gpio_data, gpio_en, gpio_dir, gpio_unsol_mask} <= {4{hgv_pkg::GPIO_RST}};
    else if (cmd_take && afg)
    begin
      // upper payload bits have no pins behind them and are dropped
      unique case (verb)
        hgv_pkg::VERB_SET_GPIO_DATA: gpio_data <= payload[1:0];
        hgv_pkg::VERB_SET_GPIO_EN: gpio_en <= payload[1:0];
        hgv_pkg::VERB_SET_GPIO_DIR: gpio_dir <= payload[1:0];
        hgv_pkg::VERB_SET_GPIO_UNSOL: gpio_unsol_mask <= payload[1:0];
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // gpio pads
  // enabled outputs read back the stored level, enabled inputs the pad
  assign gpio_level = gpio_en & ((gpio_dir & gpio_data) | (~gpio_dir & gpio_s2));

  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      {gpio_out, gpio_oe_out} <= 4'h0;
    else
      {gpio_out, gpio_oe_out} <= {gpio_data, gpio_en & gpio_dir};
  end

  // ==========================================================================
  // unsolicited responses
  logic [1:0] gpio_change;
  logic gpio_pend;
  logic [7:0] port_pend;
  logic [7:0] port_enabled;
  logic [7:0] port_change;
  logic [9:0] pres_q;
  logic send_gpio;
  logic send_port;
  logic [2:0] port_sel;
  logic [7:0] port_sent;

  always_comb
  begin
    for (int i = 0; i < hgv_pkg::NUM_PORTS; i++)
      port_enabled[i] = unsol_ctl[i][hgv_pkg::UNSOL_EN_BIT];
  end

  assign gpio_change = (gpio_level ^ gpio_level_q) & gpio_unsol_mask;
  assign port_change = (pres_s2[7:0] ^ pres_q[7:0]) & port_enabled;
  assign send_gpio = gpio_pend;
  assign send_port = !gpio_pend && (port_pend != 8'h00);

  always_comb
  begin
    port_sel = 3'h0;
    for (int i = hgv_pkg::NUM_PORTS - 1; i >= 0; i--)
      if (port_pend[i])
        port_sel = 3'(i);
  end

  assign port_sent = send_port ? (8'h01 << port_sel) : 8'h00;

  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      {gpio_level_q, pres_q} <= 12'h000;
    else
      {gpio_level_q, pres_q} <= {gpio_level, pres_s2};
  end

  // a new event in the sending cycle stays pending
  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      {gpio_pend, port_pend} <= 9'h000;
    else if (soft_clr)
      {gpio_pend, port_pend} <= 9'h000;
    else
    begin
      gpio_pend <= (gpio_pend & ~send_gpio)
                   | ((gpio_change != 2'h0) && unsol_ctl[9][hgv_pkg::UNSOL_EN_BIT]);
      port_pend <= (port_pend & ~port_sent) | port_change;
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      {unsol_valid_out, unsol_data_out} <= 33'h000000000;
    else
    begin
      unsol_valid_out <= send_gpio || send_port;
      if (send_gpio)
        unsol_data_out <= {unsol_ctl[9][3:0], 24'h000000, hgv_pkg::UNSOL_SRC_GPIO};
      else if (send_port)
        unsol_data_out <= {unsol_ctl[port_sel][3:0], 24'h000000, 1'b0, port_sel};
      else
        unsol_data_out <= 32'h00000000;
    end
  end

  // ==========================================================================
  // response
  logic [31:0] next_resp;

  // anything not listed, including every set verb, answers zero
  always_comb
  begin
    next_resp = 32'h00000000;
    unique case (verb)
      hgv_pkg::VERB_GET_UNSOL:
        if (has_unsol(node_identifier))
          next_resp = {24'h000000, unsol_ctl[unsol_index(node_identifier)]};
      hgv_pkg::VERB_GET_SENSE:
        if (is_pin(node_identifier))
          next_resp = {pres_s2[pin_index(node_identifier)], 31'h00000000};
      hgv_pkg::VERB_GET_CFG:
        if (is_pin(node_identifier))
          next_resp = cfg_word[pin_index(node_identifier)];
      hgv_pkg::VERB_GET_BEEP:
        if (afg)
          next_resp = {24'h000000, beep_div};
      hgv_pkg::VERB_GET_GPIO_DATA:
        if (afg)
          next_resp = {30'h00000000, gpio_level};
      hgv_pkg::VERB_GET_GPIO_EN:
        if (afg)
          next_resp = {30'h00000000, gpio_en};
      hgv_pkg::VERB_GET_GPIO_DIR:
        if (afg)
          next_resp = {30'h00000000, gpio_dir};
      hgv_pkg::VERB_GET_GPIO_UNSOL:
        if (afg)
          next_resp = {30'h00000000, gpio_unsol_mask};
      hgv_pkg::VERB_GET_DIG_CTL1, hgv_pkg::VERB_GET_DIG_CTL2:
        if (node_identifier == hgv_pkg::NID_DIG_OUT)
          next_resp = {16'h0000, digital_converter_control_bits_out_in};
        else if (node_identifier == hgv_pkg::NID_DIG_IN)
          next_resp = {16'h0000, digital_converter_control_bits_in_in};
      default: ;
    endcase
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      {resp_valid_out, resp_data_out} <= 33'h000000000;
    else
    begin
      resp_valid_out <= cmd_take;
      resp_data_out <= cmd_take ? next_resp : 32'h00000000;
    end
  end

  // ==========================================================================
  // beep
  hgv_beep_gen u_beep
  (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .divider_in(beep_div),
    .ext_beep_in(beep_s2),
    .beep_out(beep_out)
  );
endmodule

// ===== src/hgv_pkg.sv
// constants for the codec pin, gpio and beep verb decoder
package hgv_pkg;
  // ==========================================================================
  // clock and timing
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned SAMPLE_HZ = 48_000;
  localparam int unsigned SAMPLE_TICK_CYCLES = CLK_HZ / SAMPLE_HZ;
  localparam int unsigned BEEP_DIV_SCALE = 4;
  // ==========================================================================
  // command word fields
  localparam int unsigned CAD_MSB = 31;
  localparam int unsigned CAD_LSB = 28;
  localparam int unsigned NID_MSB = 27;
  localparam int unsigned NID_LSB = 20;
  localparam int unsigned VERB_MSB = 19;
  localparam int unsigned VERB_LSB = 8;
  // ==========================================================================
  // node identifiers
  localparam logic [7:0] NID_AFG = 8'h01;
  localparam logic [7:0] NID_DIG_OUT = 8'h06;
  localparam logic [7:0] NID_DIG_IN = 8'h0A;
  localparam logic [7:0] NID_PORT_FIRST = 8'h14;
  localparam logic [7:0] NID_PORT_LAST = 8'h1B;
  localparam logic [7:0] NID_PIN_1E = 8'h1E;
  localparam logic [7:0] NID_PIN_1F = 8'h1F;
  localparam int unsigned NUM_PINS = 10;
  localparam int unsigned NUM_PORTS = 8;
  localparam int unsigned NUM_GPIO = 2;
  // ==========================================================================
  // verb codes
  localparam logic [11:0] VERB_GET_UNSOL = 12'hF08;
  localparam logic [11:0] VERB_SET_UNSOL = 12'h708;
  localparam logic [11:0] VERB_GET_SENSE = 12'hF09;
  localparam logic [11:0] VERB_EXEC_SENSE = 12'h709;
  localparam logic [11:0] VERB_GET_CFG = 12'hF1C;
  localparam logic [11:0] VERB_SET_CFG0 = 12'h71C;
  localparam logic [11:0] VERB_SET_CFG1 = 12'h71D;
  localparam logic [11:0] VERB_SET_CFG2 = 12'h71E;
  localparam logic [11:0] VERB_SET_CFG3 = 12'h71F;
  localparam logic [11:0] VERB_GET_BEEP = 12'hF0A;
  localparam logic [11:0] VERB_SET_BEEP = 12'h70A;
  localparam logic [11:0] VERB_GET_GPIO_DATA = 12'hF15;
  localparam logic [11:0] VERB_SET_GPIO_DATA = 12'h715;
  localparam logic [11:0] VERB_GET_GPIO_EN = 12'hF16;
  localparam logic [11:0] VERB_SET_GPIO_EN = 12'h716;
  localparam logic [11:0] VERB_GET_GPIO_DIR = 12'hF17;
  localparam logic [11:0] VERB_SET_GPIO_DIR = 12'h717;
  localparam logic [11:0] VERB_GET_GPIO_UNSOL = 12'hF19;
  localparam logic [11:0] VERB_SET_GPIO_UNSOL = 12'h719;
  localparam logic [11:0] VERB_FUNC_RESET = 12'h7FF;
  localparam logic [11:0] VERB_GET_DIG_CTL1 = 12'hF0D;
  localparam logic [11:0] VERB_GET_DIG_CTL2 = 12'hF0E;
  // ==========================================================================
  // field positions and reset values
  localparam int unsigned UNSOL_EN_BIT = 7;
  localparam logic [7:0] UNSOL_KEEP_MASK = 8'h8F;
  localparam int unsigned SENSE_PRESENT_BIT = 31;
  localparam logic [7:0] UNSOL_CTL_RST = 8'h00;
  localparam logic [7:0] BEEP_DIV_RST = 8'h00;
  localparam logic [1:0] GPIO_RST = 2'h0;
  localparam logic [31:0] CFG_DEFAULT_RST = 32'h00000000;
  localparam logic [3:0] UNSOL_SRC_GPIO = 4'hF;
endpackage

// ===== src/hgv_beep_gen.sv
// beep tone divider with external beep pass-through
`timescale 1ns/1ps
module hgv_beep_gen
(
  input wire logic ref_clk_in, // 10 MHz clock
  input wire logic sys_rst_in, // async reset, active high
  input wire logic [7:0] divider_in, // tone divider, zero selects external
  input wire logic ext_beep_in, // synchronised external beep
  output logic beep_out // tone out, registered
);
  // ==========================================================================
  // 48 kHz tick
  logic [7:0] tick_cnt;
  logic tick;
  logic [8:0] half_cnt;
  logic tone;
  logic [8:0] half_len;

  assign tick = (tick_cnt == 8'(hgv_pkg::SAMPLE_TICK_CYCLES - 1));
  // period is four times the divider in sample ticks, so each half is two
  assign half_len = 9'(hgv_pkg::BEEP_DIV_SCALE / 2) * {1'b0, divider_in};

  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      tick_cnt <= 8'h00;
    else if (tick)
      tick_cnt <= 8'h00;
    else
      tick_cnt <= tick_cnt + 8'h01;
  end

  // ==========================================================================
  // tone toggle
  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      half_cnt <= 9'h000;
      tone <= 1'b0;
    end
    else if (divider_in == 8'h00)
    begin
      half_cnt <= 9'h000;
      tone <= 1'b0;
    end
    else if (tick)
    begin
      if (half_cnt >= half_len - 9'h001)
      begin
        half_cnt <= 9'h000;
        tone <= ~tone;
      end
      else
        half_cnt <= half_cnt + 9'h001;
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      beep_out <= 1'b0;
    else
      beep_out <= (divider_in == 8'h00) ? ext_beep_in : tone;
  end
endmodule

// ===== sim/hgv_host_model.sv
// link controller model: frames command words and keeps the last response
`timescale 1ns/1ps
module hgv_host_model
(
  input wire logic ref_clk_in, // clock
  input wire logic send_in, // issue word_in this cycle
  input wire logic [31:0] word_in, // command word
  input wire logic resp_valid_in, // response strobe
  input wire logic [31:0] resp_data_in, // response word
  output logic cmd_valid_out = 1'b0, // command strobe
  output logic [31:0] cmd_data_out = 32'h0, // command word
  output logic [31:0] resp_out = 32'h0, // last response
  output logic [7:0] resp_cnt_out = 8'h0 // responses seen
);
  // ==========================================================================
  // command framing
  always_ff @(posedge ref_clk_in)
  begin
    cmd_valid_out <= send_in;
    // an idle bus toggles so stale words never look valid
    cmd_data_out <= send_in ? word_in : ~cmd_data_out;
    if (resp_valid_in)
    begin
      resp_out <= resp_data_in;
      resp_cnt_out <= resp_cnt_out + 8'h01;
    end
  end
endmodule

// ===== sim/hgv_verb_sva.sv
// port assertions for the verb decoder
`timescale 1ns/1ps
module hgv_verb_sva
(
  input wire logic ref_clk_in, // clock
  input wire logic sys_rst_in, // reset
  input wire logic [3:0] codec_link_address_in, // strap
  input wire logic cmd_valid_in, // command strobe
  input wire logic [31:0] cmd_data_in, // command word
  input wire logic resp_valid_out, // response strobe
  input wire logic [31:0] resp_data_out, // response word
  input wire logic unsol_valid_out, // unsol strobe
  input wire logic [31:0] unsol_data_out // unsol word
);
  // ==========================================================================
  // checks
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  logic [11:0] verb;
  assign verb = cmd_data_in[19:8];
  a_resp_has_cmd: assert property (resp_valid_out |-> $past(cmd_valid_in))
    else $error("response without command");
  a_addr_filter: assert property (cmd_valid_in &&
    cmd_data_in[31:28] != codec_link_address_in |=> !resp_valid_out)
    else $error("foreign address answered");
  a_set_zero: assert property (resp_valid_out && $past(verb[11:8]) == 4'h7
    |-> resp_data_out == 32'h0) else $error("set verb answer not zero");
  a_sense_low: assert property (resp_valid_out && $past(verb) == 12'hF09
    |-> resp_data_out[30:0] == 31'h0) else $error("sense impedance not zero");
  a_dig_upper: assert property (resp_valid_out && $past(verb) inside {12'hF0D, 12'hF0E}
    |-> resp_data_out[31:16] == 16'h0) else $error("digital upper half not zero");
  a_gpio_upper: assert property (resp_valid_out &&
    $past(verb) inside {12'hF15, 12'hF16, 12'hF17, 12'hF19}
    |-> resp_data_out[31:2] == 30'h0) else $error("gpio upper bits not zero");
  a_cfg_bypass: assert property (resp_valid_out && $past(verb) == 12'hF1C &&
    $past(verb, 2) == 12'h71C && $past(cmd_valid_in, 2) &&
    $past(cmd_data_in[31:28], 2) == codec_link_address_in &&
    $past(cmd_data_in[27:20], 2) == 8'h14 && $past(cmd_data_in[27:20]) == 8'h14
    |-> resp_data_out[7:0] == $past(cmd_data_in[7:0], 2)) else $error("config byte lost");
  a_unsol_form: assert property (unsol_valid_out |-> unsol_data_out[27:4] == 24'h0)
    else $error("unsol word malformed");
endmodule

bind hgv_verb_decoder hgv_verb_sva u_sva (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
  .codec_link_address_in(codec_link_address_in), .cmd_valid_in(cmd_valid_in),
  .cmd_data_in(cmd_data_in), .resp_valid_out(resp_valid_out), .resp_data_out(resp_data_out),
  .unsol_valid_out(unsol_valid_out), .unsol_data_out(unsol_data_out));

// ===== sim/hda_codec_pin_gpio_beep_verbs_tb.sv
// self-checking bench for the verb decoder
`timescale 1ns/1ps
module hda_codec_pin_gpio_beep_verbs_tb;
  logic clk = 1'b0, rst = 1'b1, lrst_n = 1'b1, eb = 1'b0, send = 1'b0;
  logic [9:0] pres = 10'h0;
  logic [15:0] dc0 = 16'h1234, dc1 = 16'h00A5;
  logic [1:0] gpad = 2'h0;
  logic [31:0] word = 32'h0, mresp, cd, rd, ud;
  logic [7:0] mcnt;
  logic cv, rv, uv, beep;
  logic [9:0] sr;
  logic [1:0] go, goe, gin;
  int error_cnt = 0, checks = 0, cyc = 0, n;
  logic [31:0] d;
  time t0;
  // pad level resolves the design drive against the outside drive
  assign gin = (goe & go) | (~goe & gpad);
  always #50 clk = ~clk;
  hgv_host_model HOST (.ref_clk_in(clk), .send_in(send), .word_in(word), .resp_valid_in(rv),
    .resp_data_in(rd), .cmd_valid_out(cv), .cmd_data_out(cd), .resp_out(mresp),
    .resp_cnt_out(mcnt));
  hgv_verb_decoder DUT (.ref_clk_in(clk), .sys_rst_in(rst), .link_rst_n_in(lrst_n),
    .codec_link_address_in(4'h3), .cmd_valid_in(cv), .cmd_data_in(cd), .resp_valid_out(rv),
    .resp_data_out(rd), .unsol_valid_out(uv), .unsol_data_out(ud), .pin_presence_in(pres),
    .sense_right_out(sr), .digital_converter_control_bits_out_in(dc0),
    .digital_converter_control_bits_in_in(dc1), .gpio_in(gin), .gpio_out(go),
    .gpio_oe_out(goe), .external_beep_input_in(eb), .beep_out(beep));
  // ==========================================================================
  // shared tasks
  function automatic logic [31:0] w(input logic [7:0] nd, input logic [11:0] v,
    input logic [7:0] p);
    return {4'h3, nd, v, p};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmd(input logic [31:0] x, input logic [31:0] y = 32'h0, input bit two = 0);
    @(posedge clk);
    send <= 1'b1;
    word <= x;
    if (two)
    begin
      @(posedge clk);
      word <= y;
    end
    @(posedge clk);
    send <= 1'b0;
    // the model latches the answer two edges before the caller looks
    repeat (4) @(posedge clk);
  endtask
  task automatic get(input logic [7:0] nd, input logic [11:0] v, input logic [31:0] e);
    cmd(w(nd, v, 8'h00));
    chk("response", e, mresp);
  endtask
  task automatic wu();
    n = 0;
    repeat (12)
    begin
      @(negedge clk);
      if (uv === 1'b1)
      begin
        n++;
        d = ud;
      end
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_cfg();
    cmd(w(8'h14, 12'h71C, 8'hA5), w(8'h14, 12'hF1C, 8'h00), 1);
    chk("cfg back to back", 32'hA5, mresp);
    for (int i = 0; i < 4; i++)
      cmd(w(8'h1F, 12'h71C + 12'(i), 8'(8'h11 * (i + 1))));
    get(8'h1F, 12'hF1C, 32'h44332211);
    cmd(w(8'h1C, 12'h71C, 8'hFF));
    get(8'h1E, 12'hF1C, 32'h0);
    lrst_n <= 1'b0;
    repeat (5) @(posedge clk);
    lrst_n <= 1'b1;
    repeat (4) @(posedge clk);
    get(8'h1F, 12'hF1C, 32'h44332211);
    $display("config test done");
  endtask
  task automatic t_sense();
    pres <= 10'h101;
    repeat (4) @(posedge clk);
    get(8'h14, 12'hF09, 32'h80000000);
    get(8'h15, 12'hF09, 32'h0);
    get(8'h1E, 12'hF09, 32'h80000000);
    get(8'h01, 12'hF09, 32'h0);
    cmd(w(8'h15, 12'h709, 8'h01));
    chk("sense select", 32'h2, {22'h0, sr});
    $display("sense test done");
  endtask
  task automatic t_beep();
    cmd(w(8'h01, 12'h70A, 8'h01));
    cmd(w(8'h14, 12'h70A, 8'h55));
    get(8'h01, 12'hF0A, 32'h1);
    @(posedge beep);
    t0 = $time;
    @(posedge beep);
    chk("beep period", 32'(4 * hgv_pkg::SAMPLE_TICK_CYCLES), 32'(($time - t0) / 100));
    cmd(w(8'h01, 12'h70A, 8'h00));
    eb <= 1'b1;
    repeat (6) @(posedge clk);
    chk("beep pass", 32'h1, {31'h0, beep});
    eb <= 1'b0;
    repeat (6) @(posedge clk);
    chk("beep pass", 32'h0, {31'h0, beep});
    $display("beep test done");
  endtask
  task automatic t_gpio();
    cmd(w(8'h01, 12'h716, 8'hFF));
    cmd(w(8'h01, 12'h717, 8'h01));
    cmd(w(8'h01, 12'h715, 8'h03));
    chk("gpio pads", 32'hD, {28'h0, go, goe});
    gpad <= 2'b10;
    repeat (4) @(posedge clk);
    get(8'h01, 12'hF15, 32'h3);
    get(8'h01, 12'hF16, 32'h3);
    get(8'h01, 12'hF17, 32'h1);
    get(8'h14, 12'hF15, 32'h0);
    cmd(w(8'h01, 12'h708, 8'hF5));
    get(8'h01, 12'hF08, 32'h85);
    cmd(w(8'h01, 12'h719, 8'h02));
    get(8'h01, 12'hF19, 32'h2);
    gpad <= 2'b00;
    wu();
    chk("unsol count", 32'h1, 32'(n));
    chk("unsol word", 32'h5000000F, d);
    cmd(w(8'h01, 12'h708, 8'h05));
    gpad <= 2'b10;
    wu();
    chk("unsol count", 32'h0, 32'(n));
    $display("gpio test done");
  endtask
  task automatic t_misc();
    cmd(w(8'h01, 12'h7FF, 8'h00));
    chk("reset answer", 32'h0, mresp);
    get(8'h01, 12'hF16, 32'h0);
    get(8'h1F, 12'hF1C, 32'h44332211);
    get(8'h06, 12'hF0D, 32'h1234);
    get(8'h0A, 12'hF0E, 32'hA5);
    cmd(w(8'h14, 12'h708, 8'h83));
    get(8'h14, 12'hF08, 32'h83);
    get(8'h1E, 12'hF08, 32'h0);
    pres <= 10'h000;
    wu();
    chk("unsol count", 32'h1, 32'(n));
    chk("unsol word", 32'h30000000, d);
    d = 32'(mcnt);
    cmd({4'h5, 8'h01, 12'hF16, 8'h00});
    chk("foreign address", d, 32'(mcnt));
    $display("misc test done");
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      conclude();
    end
  end
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_cfg();
    t_sense();
    t_beep();
    t_gpio();
    t_misc();
    conclude();
  end
endmodule
